// ==== core/cwd_pkg.sv ====
package cwd_pkg;
   // Word one field positions
   localparam int CKSM_HI = 15;
   localparam int CKSM_LO = 14;
   localparam int PBDIV_HI = 13;
   localparam int PBDIV_LO = 12;
   localparam int CLKOUT_N_BIT = 10;
   localparam int POSC_HI = 9;
   localparam int POSC_LO = 8;
   localparam int TWOSPD_BIT = 7;
   localparam int SOSC_BIT = 5;
   localparam int STARTUP_OSC_SELECT_HI = 2;
   localparam int STARTUP_OSC_SELECT_LO = 0;
   // Word two field positions
   localparam int ODIV_HI = 18;
   localparam int ODIV_LO = 16;
   localparam int UPLL_DIS_BIT = 15;
   localparam int UIDIV_HI = 10;
   localparam int UIDIV_LO = 8;
   localparam int MUL_HI = 6;
   localparam int MUL_LO = 4;
   localparam int IDIV_HI = 2;
   localparam int IDIV_LO = 0;
   // Word three field positions
   localparam int VBUS_OWN_BIT = 31;
   localparam int ID_OWN_BIT = 30;
   localparam int REMAP_1WAY_BIT = 29;
   localparam int MODDIS_1WAY_BIT = 28;
   localparam int UID_HI = 15;
   localparam int UID_LO = 0;
   // Erased flash value of every word
   localparam logic [31:0] CFG_ERASED = 32'hFFFF_FFFF;
   // Primary oscillator modes
   localparam logic [1:0] POSC_OFF = 2'h3;
   localparam logic [1:0] POSC_EXT = 2'h0;
   // Reset values of the decoded outputs
   localparam logic [3:0] RST_PBDIV = 4'h8;
   localparam logic [8:0] RST_ODIV = 9'h100;
   localparam logic [3:0] RST_IDIV = 4'hC;
   localparam logic [4:0] RST_MUL = 5'h18;
   localparam logic [15:0] RST_UID = 16'h0000;
   // Divider and multiplier table entries
   localparam logic [2:0] ODIV_TOP_CODE = 3'h7;
   localparam logic [8:0] ODIV_TOP = 9'h100;
   localparam logic [2:0] IDIV_TEN_CODE = 3'h6;
   localparam logic [2:0] IDIV_TWELVE_CODE = 3'h7;
   localparam logic [3:0] IDIV_TEN = 4'hA;
   localparam logic [3:0] IDIV_TWELVE = 4'hC;
   localparam logic [2:0] MUL_TOP_CODE = 3'h7;
   localparam logic [4:0] MUL_TOP = 5'h18;
   localparam logic [4:0] MUL_BASE = 5'hF;
   // Start-up source codes
   typedef enum logic [2:0] {
      CWD_SRC_FRC = 3'h0, CWD_SRC_FAST_RC_DIVIDED_PLL = 3'h1, CWD_SRC_PRI = 3'h2,
      CWD_SRC_PRI_PLL = 3'h3, CWD_SRC_SEC = 3'h4, CWD_SRC_LOW_POWER_RC_OSC = 3'h5,
      CWD_SRC_FRC16 = 3'h6, CWD_SRC_FAST_RC_DIVIDED = 3'h7
   } cwd_src_t;
endpackage

// ==== core/cwd_config_word_decoder.sv ====
`timescale 1ns/1ps
module cwd_config_word_decoder
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Configuration words from program memory
   input wire logic [31:0] cfgWordOne,
   input wire logic [31:0] cfgWordTwo,
   input wire logic [31:0] cfgWordThree,
   // Lock control writes (after system unlock)
   input wire logic unlocked,
   input wire logic remapLockWr,
   input wire logic remapLockVal,
   input wire logic modDisLockWr,
   input wire logic modDisLockVal,
   // Register write requests from the core
   input wire logic remapRegWr,
   input wire logic modDisRegWr,
   // Clock configuration
   output logic clkSwitchEn,
   output logic failSafeEn,
   output logic [3:0] periphBusDiv,
   output logic clockOutEn,
   output logic [1:0] primaryOscMode,
   output logic twoSpeedStartupEn,
   output logic secondaryOscEn,
   output cwd_pkg::cwd_src_t startupOscSelect,
   // PLL configuration
   output logic [8:0] pllOutputDivisor,
   output logic usbPllDisable,
   output logic [3:0] usbPllInputDivider,
   output logic [4:0] pllMultiplier,
   output logic [3:0] pllInputDivider,
   // Pin ownership and identifier
   output logic busPowerPinOwner,
   output logic idPinOwner,
   output logic [15:0] userIdentifier,
   // Lock state and write grants
   output logic pinRemapLock,
   output logic moduleDisableLock,
   output logic remapWrGrant,
   output logic modDisWrGrant,
   // Raw word readback for the programming ports
   output logic [31:0] devConfigWordOne,
   output logic [31:0] devConfigWordTwo,
   output logic [31:0] devConfigWordThree
);
   import cwd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Divider and multiplier tables
   function automatic logic [3:0] inDiv(input logic [2:0] c);
      case (c)
         IDIV_TEN_CODE: inDiv = IDIV_TEN;
         IDIV_TWELVE_CODE: inDiv = IDIV_TWELVE;
         default: inDiv = 4'(c) + 4'h1;
      endcase
   endfunction

   function automatic logic [4:0] mulVal(input logic [2:0] c);
      if (c == MUL_TOP_CODE) begin
         mulVal = MUL_TOP;
      end else begin
         mulVal = 5'(c) + MUL_BASE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Word capture: held at erased value during reset, sampled at release
   logic loaded_q;
   logic [31:0] w1_q, w2_q, w3_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         loaded_q <= 1'b0;
         w1_q <= CFG_ERASED;
         w2_q <= CFG_ERASED;
         w3_q <= CFG_ERASED;
      end else if (!loaded_q) begin
         loaded_q <= 1'b1;
         w1_q <= cfgWordOne;
         w2_q <= cfgWordTwo;
         w3_q <= cfgWordThree;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock switching and fail-safe monitor
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clkSwitchEn <= 1'b0;
         failSafeEn <= 1'b0;
      end else begin
         clkSwitchEn <= !w1_q[CKSM_HI];
         failSafeEn <= !w1_q[CKSM_HI] && !w1_q[CKSM_LO];
      end
   end

   // Peripheral bus clock divisor
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         periphBusDiv <= RST_PBDIV;
      end else begin
         periphBusDiv <= 4'(4'h1 << w1_q[PBDIV_HI:PBDIV_LO]);
      end
   end

   // Clock output on the oscillator output pin
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clockOutEn <= 1'b0;
      end else begin
         clockOutEn <= !w1_q[CLKOUT_N_BIT] &&
            (w1_q[POSC_HI:POSC_LO] == POSC_OFF ||
             w1_q[POSC_HI:POSC_LO] == POSC_EXT);
      end
   end

   // Primary oscillator mode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         primaryOscMode <= POSC_OFF;
      end else begin
         primaryOscMode <= w1_q[POSC_HI:POSC_LO];
      end
   end

   // Two-speed start-up
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         twoSpeedStartupEn <= 1'b0;
      end else begin
         twoSpeedStartupEn <= w1_q[TWOSPD_BIT];
      end
   end

   // Secondary oscillator enable
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         secondaryOscEn <= 1'b0;
      end else begin
         secondaryOscEn <= w1_q[SOSC_BIT];
      end
   end

   // Start-up oscillator source
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         startupOscSelect <= CWD_SRC_FRC;
      end else begin
         startupOscSelect <= cwd_src_t'(w1_q[STARTUP_OSC_SELECT_HI:STARTUP_OSC_SELECT_LO]);
      end
   end

   // PLL output divisor
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pllOutputDivisor <= RST_ODIV;
      end else begin
         pllOutputDivisor <=
            (w2_q[ODIV_HI:ODIV_LO] == ODIV_TOP_CODE) ? ODIV_TOP :
            9'(9'h1 << w2_q[ODIV_HI:ODIV_LO]);
      end
   end

   // USB PLL bypass
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         usbPllDisable <= 1'b1;
      end else begin
         usbPllDisable <= w2_q[UPLL_DIS_BIT];
      end
   end

   // USB PLL input divider
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         usbPllInputDivider <= RST_IDIV;
      end else begin
         usbPllInputDivider <= inDiv(w2_q[UIDIV_HI:UIDIV_LO]);
      end
   end

   // PLL multiplier
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pllMultiplier <= RST_MUL;
      end else begin
         pllMultiplier <= mulVal(w2_q[MUL_HI:MUL_LO]);
      end
   end

   // Main PLL input divider
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pllInputDivider <= RST_IDIV;
      end else begin
         pllInputDivider <= inDiv(w2_q[IDIV_HI:IDIV_LO]);
      end
   end

   // Bus-power pin ownership
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busPowerPinOwner <= 1'b0;
      end else begin
         busPowerPinOwner <= w3_q[VBUS_OWN_BIT];
      end
   end

   // Identification pin ownership
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idPinOwner <= 1'b0;
      end else begin
         idPinOwner <= w3_q[ID_OWN_BIT];
      end
   end

   // User identifier
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         userIdentifier <= RST_UID;
      end else begin
         userIdentifier <= w3_q[UID_HI:UID_LO];
      end
   end

   // Raw words for the programming ports
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         devConfigWordOne <= CFG_ERASED;
         devConfigWordTwo <= CFG_ERASED;
         devConfigWordThree <= CFG_ERASED;
      end else begin
         devConfigWordOne <= w1_q;
         devConfigWordTwo <= w2_q;
         devConfigWordThree <= w3_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One-way lock controls
   logic remapSetOnce_q, modDisSetOnce_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinRemapLock <= 1'b0;
         remapSetOnce_q <= 1'b0;
      end else if (loaded_q && unlocked && remapLockWr) begin
         if (!(w3_q[REMAP_1WAY_BIT] && remapSetOnce_q)) begin
            pinRemapLock <= remapLockVal;
            remapSetOnce_q <= remapSetOnce_q | remapLockVal;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         moduleDisableLock <= 1'b0;
         modDisSetOnce_q <= 1'b0;
      end else if (loaded_q && unlocked && modDisLockWr) begin
         if (!(w3_q[MODDIS_1WAY_BIT] && modDisSetOnce_q)) begin
            moduleDisableLock <= modDisLockVal;
            modDisSetOnce_q <= modDisSetOnce_q | modDisLockVal;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write grants for remap and module-disable registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         remapWrGrant <= 1'b0;
         modDisWrGrant <= 1'b0;
      end else begin
         remapWrGrant <= remapRegWr && !pinRemapLock;
         modDisWrGrant <= modDisRegWr && !moduleDisableLock;
      end
   end

endmodule // cwd_config_word_decoder

// ==== sim/cwd_programmer_model.sv ====
`timescale 1ns/1ps
module cwd_programmer_model (
   // Word set select
   input logic [2:0] setSel,
   // Programmed words
   output logic [31:0] cfgWordOne,
   output logic [31:0] cfgWordTwo,
   output logic [31:0] cfgWordThree
);
   // Field values laid over an all-ones image
   always_comb begin
      cfgWordOne = 32'hFFFFFFFF;
      cfgWordTwo = 32'hFFFFFFFF;
      cfgWordThree = 32'hFFFFFFFF;
      cfgWordOne[15:12] = {setSel[1:0], setSel[1:0]};
      cfgWordOne[10:7] = {setSel[0], setSel[2:1], setSel[0]};
      cfgWordOne[5] = setSel[1];
      cfgWordOne[2:0] = setSel;
      cfgWordTwo[18:15] = {setSel, setSel[0]};
      cfgWordTwo[10:8] = setSel;
      cfgWordTwo[6:4] = setSel;
      cfgWordTwo[2:0] = ~setSel;
      cfgWordThree[31:28] = {setSel[0], setSel[1], setSel[2], setSel[0]};
      cfgWordThree[15:0] = {13'h1A5C, setSel};
   end
endmodule // cwd_programmer_model

// ==== sim/cwd_config_word_decoder_chk.sv ====
`timescale 1ns/1ps
module cwd_config_word_decoder_chk (
   // Clock and reset
   input logic sys_clk,
   input logic rst,
   // Words and requests
   input logic [31:0] cfgWordOne,
   input logic [31:0] cfgWordTwo,
   input logic [31:0] cfgWordThree,
   input logic remapRegWr,
   input logic modDisRegWr,
   // Decoded outputs
   input logic clkSwitchEn,
   input logic failSafeEn,
   input logic clockOutEn,
   input logic usbPllDisable,
   input logic busPowerPinOwner,
   input logic idPinOwner,
   input logic pinRemapLock,
   input logic moduleDisableLock,
   input logic remapWrGrant,
   input logic modDisWrGrant,
   input logic [3:0] periphBusDiv,
   input logic [8:0] pllOutputDivisor,
   input logic [4:0] pllMultiplier,
   // Words read back
   input logic [31:0] devConfigWordOne,
   input logic [31:0] devConfigWordTwo,
   input logic [31:0] devConfigWordThree
);
   logic [31:0] refOne_q, refTwo_q, refThree_q;
   logic [1:0] age_q;
   wire [31:0] a = refOne_q;
   wire [31:0] b = refTwo_q;
   wire [31:0] c = refThree_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   //////////////////////////////////////////////////////////////
   // Own copy of the words, taken at the first edge after release
   // Decoded outputs settled two edges after release
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         age_q <= 2'h0;
         refOne_q <= 32'hFFFFFFFF;
         refTwo_q <= 32'hFFFFFFFF;
         refThree_q <= 32'hFFFFFFFF;
      end else begin
         if (age_q == 2'h0) begin
            refOne_q <= cfgWordOne;
            refTwo_q <= cfgWordTwo;
            refThree_q <= cfgWordThree;
         end
         if (!age_q[1]) begin
            age_q <= age_q + 2'h1;
         end
      end
   end
   AST_CKSM:
   assert property (age_q[1] |-> clkSwitchEn == !a[15] &&
      failSafeEn == !(|a[15:14])) else $error("clock switch");
   AST_PBDIV:
   assert property (age_q[1] |-> periphBusDiv == 4'h1 << a[13:12])
      else $error("bus divisor");
   AST_CLKOUT:
   assert property (age_q[1] |-> clockOutEn == (!a[10] && a[9] == a[8]))
      else $error("clock out");
   AST_ODIV:
   assert property (age_q[1] |-> pllOutputDivisor ==
      (&b[18:16] ? 9'h100 : 9'h1 << b[18:16])) else $error("out divisor");
   AST_MUL:
   assert property (age_q[1] |-> pllMultiplier ==
      (&b[6:4] ? 5'h18 : 5'hF + b[6:4])) else $error("multiplier");
   AST_OWN:
   assert property (age_q[1] |-> {usbPllDisable, busPowerPinOwner,
      idPinOwner} == {b[15], c[31:30]}) else $error("owners");
   AST_RGRANT:
   assert property (remapWrGrant == ($past(remapRegWr) &&
      !$past(pinRemapLock))) else $error("remap grant");
   AST_MGRANT:
   assert property (modDisWrGrant == ($past(modDisRegWr) &&
      !$past(moduleDisableLock))) else $error("module grant");
   AST_ONEWAY:
   assert property (pinRemapLock && c[29] |=> pinRemapLock)
      else $error("one way");
   AST_ONEWAY_MOD:
   assert property (moduleDisableLock && c[28] |=> moduleDisableLock)
      else $error("module one way");
   AST_WORDS:
   assert property (age_q[1] |-> devConfigWordOne == a &&
      devConfigWordTwo == b && devConfigWordThree == c)
      else $error("word readback");
endmodule // cwd_config_word_decoder_chk
bind cwd_config_word_decoder cwd_config_word_decoder_chk i_chk (.*);

// ==== sim/test_config_word_decoder.sv ====
`timescale 1ns/1ps
module test_config_word_decoder;
   import cwd_pkg::*;
   logic sys_clk = 0, rst = 1, unlocked = 0, remapRegWr = 0, modDisRegWr = 0;
   logic remapLockWr = 0, remapLockVal = 0, modDisLockWr = 0, modDisLockVal = 0;
   logic clkSwitchEn, failSafeEn, clockOutEn, twoSpeedStartupEn, secondaryOscEn;
   logic usbPllDisable, busPowerPinOwner, idPinOwner, pinRemapLock;
   logic moduleDisableLock, remapWrGrant, modDisWrGrant;
   logic [1:0] primaryOscMode;
   logic [2:0] setSel = 0;
   logic [3:0] periphBusDiv, usbPllInputDivider, pllInputDivider;
   logic [4:0] pllMultiplier;
   logic [8:0] pllOutputDivisor;
   logic [15:0] userIdentifier;
   logic [31:0] cfgWordOne, cfgWordTwo, cfgWordThree;
   logic [31:0] devConfigWordOne, devConfigWordTwo, devConfigWordThree;
   cwd_src_t startupOscSelect;
   int nErrors = 0, checkCount = 0;
   cwd_config_word_decoder i_cwd_config_word_decoder (.*);
   cwd_programmer_model i_cwd_programmer_model (.*);
   always #50 sys_clk = ~sys_clk;
   //////////////////////////////////////////////////////////////
   function logic [3:0] dv(logic [2:0] k);
      return k < 6 ? k + 4'h1 : (k == 6 ? 4'hA : 4'hC);
   endfunction
   task chk(string nm, logic [31:0] got, logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task reload(logic [2:0] k);
      setSel = k;
      rst = 1;
      tick(1);
      rst = 0;
      tick(3);
   endtask
   task finalReport;
      $display("errors %0d checks %0d", nErrors, checkCount);
      if (nErrors == 0 && checkCount > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////
   // Every code of each field except the user identifier (low 3 bits only), inputs changed after capture
   task decode_all;
      for (int k = 0; k < 8; k++) begin
         reload(3'(k));
         chk("word1", devConfigWordOne, cfgWordOne);
         chk("word2", devConfigWordTwo, cfgWordTwo);
         setSel = ~setSel;
         tick(2);
         chk("switch", clkSwitchEn, !k[1]);
         chk("failsafe", failSafeEn, k[1:0] == 0);
         chk("pbdiv", periphBusDiv, 4'h1 << k[1:0]);
         chk("clkout", clockOutEn, !k[0] && k[2] == k[1]);
         chk("odiv", pllOutputDivisor, k == 7 ? 256 : 1 << k);
         chk("upll", usbPllDisable, k[0]);
         chk("mul", pllMultiplier, k == 7 ? 24 : 15 + k);
         chk("vbus", busPowerPinOwner, k[0]);
         chk("idpin", idPinOwner, k[1]);
         chk("startup", startupOscSelect, k);
         chk("posc", primaryOscMode, k[2:1]);
         chk("twospeed", twoSpeedStartupEn, k[0]);
         chk("sosc", secondaryOscEn, k[1]);
         chk("udiv", usbPllInputDivider, dv(3'(k)));
         chk("pdiv", pllInputDivider, dv(~3'(k)));
         chk("uid", userIdentifier, {13'h1A5C, k[2:0]});
         chk("word3", devConfigWordThree[15:0], {13'h1A5C, k[2:0]});
      end
   endtask
   // Locks and grants; one-way bits are k[2] (remap) and k[0] (module)
   task lock_rules(logic [2:0] k);
      unlocked = 0;
      reload(k);
      {remapRegWr, modDisRegWr} = 2'h3;
      {remapLockVal, modDisLockVal, remapLockWr, modDisLockWr} = 4'hF;
      tick(1);
      chk("locked", {pinRemapLock, moduleDisableLock}, 0);
      chk("rgrant", remapWrGrant, 1);
      chk("mgrant", modDisWrGrant, 1);
      unlocked = 1;
      {remapRegWr, modDisRegWr} = 2'h0;
      tick(1);
      chk("locks", {pinRemapLock, moduleDisableLock}, 3);
      {remapLockVal, modDisLockVal} = 2'h0;
      tick(1);
      chk("remap", pinRemapLock, k[2]);
      chk("moddis", moduleDisableLock, k[0]);
      {remapLockWr, modDisLockWr, remapRegWr, modDisRegWr} = 4'h3;
      tick(1);
      {remapRegWr, modDisRegWr} = 2'h0;
      chk("rgrant", remapWrGrant, !k[2]);
      chk("mgrant", modDisWrGrant, !k[0]);
      tick(1);
      chk("rgrant", remapWrGrant, 0);
      chk("mgrant", modDisWrGrant, 0);
   endtask
   initial begin
      tick(3);
      rst = 0;
      decode_all;
      lock_rules(3'h4);
      lock_rules(3'h1);
      finalReport;
   end
   initial begin
      #100000;
      nErrors++;
      finalReport;
   end
endmodule // test_config_word_decoder
